/* File: rtl/sensor_out_pkg.sv */
// shared types and constants for the sensor line output framer
package sensor_out_pkg;

   // ----------------------------------------
   // readout modes
   // ----------------------------------------
   localparam logic [3:0] MODE_0 = 4'h0;
   localparam logic [3:0] MODE_1 = 4'h1;
   localparam logic [3:0] MODE_2 = 4'h2;
   localparam logic [3:0] MODE_3 = 4'h3;
   localparam logic [3:0] MODE_4 = 4'h4;
   localparam logic [3:0] MODE_5 = 4'h5;
   localparam logic [3:0] MODE_6 = 4'h6;
   localparam logic [3:0] MODE_7 = 4'h7;
   localparam logic [3:0] MODE_2A = 4'h8;

   // ----------------------------------------
   // rates and clocks
   // ----------------------------------------
   localparam int INPUT_CLOCK_MHZ = 72;
   localparam int LANE_RATE_MBPS = 576;
   localparam int OUTPUT_BIT_CLOCK_MHZ = LANE_RATE_MBPS / 2;

   // ----------------------------------------
   // sync code words
   // ----------------------------------------
   localparam logic [11:0] SYNC_PREAMBLE = 12'hFFF;
   localparam logic [11:0] SYNC_ZERO = 12'h000;
   localparam logic [1:0] SYNC_LEAD = 2'h2;
   localparam logic [3:0] SYNC_TAIL = 4'h0;
   localparam logic [3:0] PROTECT_00 = 4'h0;
   localparam logic [3:0] PROTECT_01 = 4'hD;
   localparam logic [3:0] PROTECT_10 = 4'hB;
   localparam logic [3:0] PROTECT_11 = 4'h6;
   localparam logic [1:0] SYNC_LAST_IDX = 2'h3;
   localparam int TEN_BIT_SHIFT = 2;

   // ----------------------------------------
   // pixel ranges
   // ----------------------------------------
   localparam logic [11:0] PIX_MIN = 12'h001;
   localparam logic [11:0] PIX_MAX_12 = 12'hFFE;
   localparam logic [11:0] PIX_MAX_10 = 12'h3FE;

   // ----------------------------------------
   // horizontal front blanking, bit-clock cycles (low end of range)
   // ----------------------------------------
   localparam logic [8:0] FBLANK_A = 9'h190; // 400: modes 0, 1, 7
   localparam logic [8:0] FBLANK_B = 9'h198; // 408: modes 2, 2A, 4, 6
   localparam logic [8:0] FBLANK_C = 9'h196; // 406: modes 3, 5

   // ----------------------------------------
   // vertical front dummy, horizontal periods
   // ----------------------------------------
   localparam logic [5:0] VDUMMY_NORMAL = 6'h11;  // 17
   localparam logic [5:0] VDUMMY_INVERT = 6'h10;  // 16
   localparam logic [5:0] VDUMMY_2 = 6'h14;       // 20
   localparam logic [5:0] VDUMMY_3 = 6'h1D;       // 29
   localparam logic [5:0] VDUMMY_46 = 6'h10;      // 16
   localparam logic [5:0] VDUMMY_5 = 6'h2A;       // 42
   localparam logic [5:0] VDUMMY_7 = 6'h13;       // 19

   // ----------------------------------------
   // lane enables
   // ----------------------------------------
   localparam logic [9:0] LANES_10 = 10'h3FF;
   localparam logic [9:0] LANES_8 = 10'h0FF;
   localparam logic [9:0] LANES_6 = 10'h03F;
   localparam logic [9:0] LANES_4 = 10'h00F;
   localparam logic [9:0] LANES_2 = 10'h003;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef struct packed {
      logic last;
      logic [11:0] data;
   } pix_t;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_FBLANK = 6'h02,
      ST_SAV = 6'h04,
      ST_PIX = 6'h08,
      ST_EAV = 6'h10,
      ST_RBLANK = 6'h20
   } line_state_t;

endpackage

/* File: rtl/pin_sync2.sv */
// two-flop synchroniser for pin-level inputs
`timescale 1ns/100ps
module pin_sync2 #(
   parameter int W = 1
) (
   input wire logic clk_in,           // system clock
   input wire logic srst_in,          // synchronous reset
   input wire logic [W-1:0] async_in, // raw pin levels
   output logic [W-1:0] sync_out      // synchronised levels
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_regs_t;

   sync_regs_t r_ff;
   sync_regs_t nxt_r;

   always_comb begin
      nxt_r = r_ff;
      nxt_r.meta = async_in;
      nxt_r.stable = r_ff.meta;
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign sync_out = r_ff.stable;
endmodule

/* File: rtl/skid_buf2.sv */
// two-entry buffer with valid/ready on both sides
`timescale 1ns/100ps
module skid_buf2 #(
   parameter int W = 13
) (
   input wire logic clk_in,         // system clock
   input wire logic srst_in,        // synchronous reset
   input wire logic [W-1:0] wr_in,  // write data
   input wire logic wvalid_in,      // write valid
   output logic wready_out,         // not full, registered
   output logic [W-1:0] rd_out,     // head entry
   output logic rvalid_out,         // not empty, compared from the count flop
   input wire logic rready_in       // pop head
);
   typedef struct packed {
      logic [1:0][W-1:0] mem;
      logic wr_ptr;
      logic rd_ptr;
      logic [1:0] count;
      logic room;
   } buf_regs_t;

   buf_regs_t r_ff;
   buf_regs_t nxt_r;
   logic push;
   logic pop;

   always_comb begin
      push = wvalid_in && (r_ff.count != 2'h2);
      pop = rready_in && (r_ff.count != 2'h0);
      nxt_r = r_ff;
      if (push) begin
         nxt_r.mem[r_ff.wr_ptr] = wr_in;
         nxt_r.wr_ptr = ~r_ff.wr_ptr;
      end
      if (pop) begin
         nxt_r.rd_ptr = ~r_ff.rd_ptr;
      end
      if (push && !pop) begin
         nxt_r.count = r_ff.count + 2'h1;
      end else if (pop && !push) begin
         nxt_r.count = r_ff.count - 2'h1;
      end
      // ready leaves a flop, so the source never sees a comparator output
      nxt_r.room = (nxt_r.count != 2'h2);
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign wready_out = r_ff.room;
   assign rvalid_out = (r_ff.count != 2'h0);
   assign rd_out = r_ff.mem[r_ff.rd_ptr];
endmodule

/* File: rtl/sensor_sync_code_output.sv */
// line framer: sync codes, blanking and clamped pixels for one output lane group
//
// Overview of operation
// (RL1) line and frame start on sync falling edges
// (RL2) front blanking, then start code, then pixels
// (RL3) receiver finds pixel start from sync code
// (RL4) rear blanking stretches with sync period
// (RL5) sync words: all ones, zero, zero, flags
// (RL6) fourth word blanking flag for blanking lines
// (RL7) end flag set for end code only
// (RL8) twelve-bit fourth word with protection bits
// (RL9) ten-bit words are upper ten bits
// (RL10) pixels clamped away from preamble value
// (RL11) twelve-bit modes carry two fractional bits
// (RL12) blanking words are all zeros
// (RL13) lanes run 576 Mbit/s, 288 MHz DDR
// (RL14) front blanking length chosen per mode
// (RL15) controller keeps minimum horizontal sync period
// (RL16) sync period covers minimum plus blanking
// (RL17) controller keeps minimum vertical sync period
// (RL18) front dummy 17 lines, 16 inverted; code does so in modes 0, 1 only, other modes use fixed per-mode counts
// (RL19) controller uses recommended broadcast frame settings
// (RL20) controller issues per-mode sync pulses per line
// (RL21) lane count chosen per mode
// (RL22) input clock periods refer to 72 MHz
// (RL23) flip select zero normal, one inverted
// (RL24) end code follows last pixel immediately
`timescale 1ns/100ps
module sensor_sync_code_output
   import sensor_out_pkg::*;
(
   input wire logic CLK_SYS_IN,                      // 25 MHz system clock
   input wire logic SRST_IN,                         // synchronous reset, active high
   input wire logic HORIZONTAL_SYNC_IN,              // line sync pin, falling edge
   input wire logic VERTICAL_SYNC_IN,                // frame sync pin, falling edge
   input wire logic OUTPUT_BIT_CLOCK_IN,             // word pacing clock pin
   input wire logic [3:0] MODE_IN,                   // readout mode
   input wire logic VERTICAL_FLIP_SELECT_IN,         // 0 normal, 1 inverted
   input wire sensor_out_pkg::pix_t PIX_IN,          // pixel word and last flag
   input wire logic PIX_VALID_IN,                    // pixel offered
   output logic PIX_READY_OUT,                       // buffer has room
   output logic [11:0] WORD_OUT,                     // output word
   output logic WORD_VALID_OUT,                      // one-cycle word strobe
   output logic SYNC_CODE_OUT,                       // word belongs to a sync code
   output logic BLANK_LINE_OUT,                      // current line is blanking
   output logic [9:0] LANE_EN_OUT                    // active output lanes
);
   import sensor_out_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      line_state_t st;
      logic [1:0] sidx;
      logic [8:0] fb_cnt;
      logic [5:0] line_cnt;
      logic blank;
      logic hpend;
      logic [11:0] word;
      logic wvalid;
      logic sync;
      logic [9:0] lanes;
      logic bclk_d;
      logic hs_d;
      logic vs_d;
   } regs_t;

   regs_t r_ff;
   regs_t nxt_r;
   logic [2:0] pins_s;
   logic hs_s;
   logic vs_s;
   logic bclk_s;
   logic hs_fall;
   logic vs_fall;
   logic bclk_rise;
   logic ten_bit;
   logic [8:0] fb_min;
   logic [5:0] vdummy;
   pix_t head;
   logic head_valid;
   logic pop;
   logic take_line;

   // ----------------------------------------
   // per-mode lookups
   // ----------------------------------------
   function automatic logic is_ten_bit(input logic [3:0] m);
      return (m == MODE_1) || (m == MODE_7); // RL11
   endfunction

   function automatic logic [9:0] lane_mask(input logic [3:0] m);
      logic [9:0] l;
      l = LANES_6;
      if (m == MODE_0 || m == MODE_1) begin
         l = LANES_10;
      end else if (m == MODE_3) begin
         l = LANES_4;
      end else if (m == MODE_5) begin
         l = LANES_2;
      end else if (m == MODE_6) begin
         l = LANES_8;
      end
      return l; // RL21
   endfunction

   function automatic logic [8:0] fblank_len(input logic [3:0] m);
      logic [8:0] f;
      f = FBLANK_B;
      if (m == MODE_0 || m == MODE_1 || m == MODE_7) begin
         f = FBLANK_A;
      end else if (m == MODE_3 || m == MODE_5) begin
         f = FBLANK_C;
      end
      return f; // RL14
   endfunction

   function automatic logic [5:0] vdummy_len(input logic [3:0] m, input logic flip);
      logic [5:0] d;
      d = flip ? VDUMMY_INVERT : VDUMMY_NORMAL; // RL18 RL23
      if (m == MODE_2 || m == MODE_2A) begin
         d = VDUMMY_2;
      end else if (m == MODE_3) begin
         d = VDUMMY_3;
      end else if (m == MODE_4 || m == MODE_6) begin
         d = VDUMMY_46;
      end else if (m == MODE_5) begin
         d = VDUMMY_5;
      end else if (m == MODE_7) begin
         d = VDUMMY_7;
      end
      return d;
   endfunction

   function automatic logic [11:0] sync_word(input logic [1:0] idx, input logic v,
                                            input logic h, input logic ten);
      logic [11:0] w;
      logic [3:0] prot;
      prot = PROTECT_00;
      if (v && h) begin
         prot = PROTECT_11;
      end else if (v) begin
         prot = PROTECT_10;
      end else if (h) begin
         prot = PROTECT_01;
      end
      w = SYNC_ZERO; // RL5
      if (idx == 2'h0) begin
         w = SYNC_PREAMBLE;
      end else if (idx == SYNC_LAST_IDX) begin
         w = {SYNC_LEAD, v, h, prot, SYNC_TAIL}; // RL6 RL7 RL8
      end
      return ten ? (w >> TEN_BIT_SHIFT) : w; // RL9
   endfunction

   function automatic logic [11:0] clamp_pix(input logic [11:0] p, input logic ten);
      logic [11:0] hi;
      logic [11:0] v;
      hi = ten ? PIX_MAX_10 : PIX_MAX_12;
      // ten-bit modes use only the low ten source bits; the shift pair drops the rest
      v = ten ? ((p << TEN_BIT_SHIFT) >> TEN_BIT_SHIFT) : p;
      if (v < PIX_MIN) begin
         return PIX_MIN;
      end else if (v > hi) begin
         return hi; // RL10
      end
      return v;
   endfunction

   // ----------------------------------------
   // pin synchronisers and buffer
   // ----------------------------------------
   pin_sync2 #(.W(3)) u_pins (
      .clk_in(CLK_SYS_IN),
      .srst_in(SRST_IN),
      .async_in({HORIZONTAL_SYNC_IN, VERTICAL_SYNC_IN, OUTPUT_BIT_CLOCK_IN}),
      .sync_out(pins_s)
   );

   // a stalled line keeps up to two pixels here, so the source only waits
   skid_buf2 #(.W($bits(pix_t))) u_buf (
      .clk_in(CLK_SYS_IN),
      .srst_in(SRST_IN),
      .wr_in(PIX_IN),
      .wvalid_in(PIX_VALID_IN),
      .wready_out(PIX_READY_OUT),
      .rd_out(head),
      .rvalid_out(head_valid),
      .rready_in(pop)
   );

   // ----------------------------------------
   // line sequencing
   // ----------------------------------------
   always_comb begin
      hs_s = pins_s[2];
      vs_s = pins_s[1];
      bclk_s = pins_s[0];
      hs_fall = r_ff.hs_d && !hs_s; // RL1
      vs_fall = r_ff.vs_d && !vs_s; // RL1
      bclk_rise = !r_ff.bclk_d && bclk_s; // RL13 RL22
      ten_bit = is_ten_bit(MODE_IN);
      fb_min = fblank_len(MODE_IN);
      vdummy = vdummy_len(MODE_IN, VERTICAL_FLIP_SELECT_IN);
      pop = (r_ff.st == ST_PIX) && bclk_rise && head_valid;
      // a fall mid-line is held until the line ends
      take_line = (r_ff.st == ST_IDLE || r_ff.st == ST_RBLANK) && (hs_fall || r_ff.hpend);

      nxt_r = r_ff;
      nxt_r.hs_d = hs_s;
      nxt_r.vs_d = vs_s;
      nxt_r.bclk_d = bclk_s;
      nxt_r.lanes = lane_mask(MODE_IN);
      nxt_r.wvalid = 1'b0;
      nxt_r.sync = 1'b0;
      nxt_r.word = SYNC_ZERO;

      if (vs_fall) begin
         nxt_r.line_cnt = '0;
      end

      case (r_ff.st)
         ST_IDLE, ST_RBLANK: begin
            if (r_ff.st == ST_RBLANK && bclk_rise) begin
               nxt_r.wvalid = 1'b1; // RL4 RL12
            end
         end
         ST_FBLANK: begin
            if (bclk_rise) begin
               nxt_r.wvalid = 1'b1; // RL12
               nxt_r.fb_cnt = r_ff.fb_cnt + 9'h001;
               if (r_ff.fb_cnt == fb_min - 9'h001) begin
                  nxt_r.st = ST_SAV; // RL2 RL14
                  nxt_r.sidx = '0;
               end
            end
         end
         ST_SAV: begin
            if (bclk_rise) begin
               nxt_r.wvalid = 1'b1;
               nxt_r.sync = 1'b1;
               nxt_r.word = sync_word(r_ff.sidx, r_ff.blank, 1'b0, ten_bit); // RL2
               nxt_r.sidx = r_ff.sidx + 2'h1;
               if (r_ff.sidx == SYNC_LAST_IDX) begin
                  // blanking lines carry no pixels
                  nxt_r.st = r_ff.blank ? ST_EAV : ST_PIX;
               end
            end
         end
         ST_PIX: begin
            if (pop) begin
               nxt_r.wvalid = 1'b1;
               nxt_r.word = clamp_pix(head.data, ten_bit); // RL10 RL11
               if (head.last) begin
                  nxt_r.st = ST_EAV; // RL24
               end
            end
         end
         ST_EAV: begin
            if (bclk_rise) begin
               nxt_r.wvalid = 1'b1;
               nxt_r.sync = 1'b1;
               nxt_r.word = sync_word(r_ff.sidx, r_ff.blank, 1'b1, ten_bit); // RL7
               nxt_r.sidx = r_ff.sidx + 2'h1;
               if (r_ff.sidx == SYNC_LAST_IDX) begin
                  nxt_r.st = ST_RBLANK; // RL4
               end
            end
         end
         default: begin
            nxt_r.st = ST_IDLE;
         end
      endcase

      if (take_line) begin
         nxt_r.st = ST_FBLANK; // RL1
         nxt_r.fb_cnt = '0;
         nxt_r.sidx = '0;
         nxt_r.hpend = 1'b0;
         nxt_r.blank = (nxt_r.line_cnt < vdummy); // RL18
         if (nxt_r.line_cnt != '1) begin
            nxt_r.line_cnt = nxt_r.line_cnt + 6'h01;
         end
      end else if (hs_fall) begin
         nxt_r.hpend = 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (SRST_IN) begin
         r_ff <= '{st: ST_IDLE, default: '0};
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign WORD_OUT = r_ff.word;
   assign WORD_VALID_OUT = r_ff.wvalid;
   assign SYNC_CODE_OUT = r_ff.sync;
   assign BLANK_LINE_OUT = r_ff.blank;
   assign LANE_EN_OUT = r_ff.lanes;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge CLK_SYS_IN);
   endclocking
   default disable iff (SRST_IN);

   AST_LINE_START: assert property ( // RL1
      (hs_fall && r_ff.st == ST_RBLANK) |=> (r_ff.st == ST_FBLANK && r_ff.fb_cnt == '0))
      else $error("line did not start on sync fall");
   AST_SAV_AFTER_BLANK: assert property ( // RL2
      (r_ff.st == ST_FBLANK && bclk_rise && r_ff.fb_cnt == fb_min - 9'h001 && !take_line)
      |=> (r_ff.st == ST_SAV && r_ff.sidx == 2'h0))
      else $error("start code did not follow front blanking");
   AST_PREAMBLE: assert property ( // RL5
      (r_ff.st == ST_SAV && bclk_rise && r_ff.sidx == 2'h0 && !take_line)
      |=> (WORD_VALID_OUT && SYNC_CODE_OUT &&
           WORD_OUT == (ten_bit ? (SYNC_PREAMBLE >> TEN_BIT_SHIFT) : SYNC_PREAMBLE)))
      else $error("first sync word not all ones");
   AST_SAV_FLAGS: assert property ( // RL6
      (r_ff.st == ST_SAV && bclk_rise && r_ff.sidx == SYNC_LAST_IDX && !take_line && !ten_bit)
      |=> (WORD_OUT[9] == $past(r_ff.blank) && WORD_OUT[8] == 1'b0))
      else $error("start code flags wrong");
   AST_EAV_WORD: assert property ( // RL8
      (r_ff.st == ST_EAV && bclk_rise && r_ff.sidx == SYNC_LAST_IDX && !take_line && !ten_bit)
      |=> (WORD_OUT == ($past(r_ff.blank) ? 12'hB60 : 12'h9D0)))
      else $error("end code fourth word wrong");
   AST_PIX_RANGE: assert property ( // RL10
      pop |=> (WORD_OUT >= PIX_MIN && WORD_OUT <= (ten_bit ? PIX_MAX_10 : PIX_MAX_12)))
      else $error("pixel outside output range");
   AST_BLANK_ZERO: assert property ( // RL12
      (WORD_VALID_OUT && !SYNC_CODE_OUT && $past(r_ff.st) != ST_PIX) |-> WORD_OUT == '0)
      else $error("blanking word not zero");
   AST_EAV_AFTER_LAST: assert property ( // RL24
      (pop && head.last && !take_line) |=> (r_ff.st == ST_EAV && r_ff.sidx == 2'h0))
      else $error("end code did not follow last pixel");
   AST_LANES: assert property ( // RL21
      !$past(SRST_IN) |-> LANE_EN_OUT == lane_mask($past(MODE_IN)))
      else $error("lane enables do not match mode");
   AST_DUMMY: assert property ( // RL18
      (take_line && vs_fall) |=> BLANK_LINE_OUT)
      else $error("first line of frame not blanking");

endmodule

/* File: tb/sync_source_model.sv */
// controller model: line and frame sync pins plus the word pacing clock
`timescale 1ns/100ps
module sync_source_model (
   output logic hsync_out,  // line sync pin
   output logic vsync_out,  // frame sync pin
   output logic bit_clk_out // word pacing clock, still between lines
);
   initial begin
      hsync_out = 1'b1;
      vsync_out = 1'b1;
      bit_clk_out = 1'b0;
   end

   // one line: sync fall, settle, then n pacing clocks; the period always
   // covers front blanking plus every word, so nothing leaks into blanking
   task automatic run_line(input int n, input bit frame);
      // step off the system clock edge before touching any pin
      #3;
      hsync_out = 1'b0;
      if (frame) vsync_out = 1'b0; // single frame start, never too soon
      #503;
      repeat (n) begin
         bit_clk_out = 1'b1;
         #160;
         bit_clk_out = 1'b0;
         #160;
      end
      hsync_out = 1'b1;
      vsync_out = 1'b1;
      #517;
   endtask
endmodule

/* File: tb/sensor_sync_code_output_tb_top.sv */
// self-checking bench for the sensor line output framer
`timescale 1ns/100ps
module sensor_sync_code_output_tb_top;
   import sensor_out_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic hsync;
   logic vsync;
   logic bclk;
   logic [3:0] mode = 4'h0;
   logic flip = 1'b1;
   pix_t pix = '0;
   logic pix_valid = 1'b0;
   logic pix_ready;
   logic word_valid;
   logic sync_code;
   logic blank_line;
   logic [11:0] word;
   logic [9:0] lane_en;
   logic [12:0] exp_q[$];
   pix_t pix_q[$];
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   // index 8 is mode 2A
   logic [9:0] lanes [9] = '{10'h3FF, 10'h3FF, 10'h03F, 10'h00F, 10'h03F,
      10'h003, 10'h0FF, 10'h03F, 10'h03F};

   sensor_sync_code_output i_dut (.CLK_SYS_IN(clk), .SRST_IN(srst),
      .HORIZONTAL_SYNC_IN(hsync), .VERTICAL_SYNC_IN(vsync), .OUTPUT_BIT_CLOCK_IN(bclk),
      .MODE_IN(mode), .VERTICAL_FLIP_SELECT_IN(flip), .PIX_IN(pix),
      .PIX_VALID_IN(pix_valid), .PIX_READY_OUT(pix_ready), .WORD_OUT(word),
      .WORD_VALID_OUT(word_valid), .SYNC_CODE_OUT(sync_code),
      .BLANK_LINE_OUT(blank_line), .LANE_EN_OUT(lane_en));

   sync_source_model i_src (.hsync_out(hsync), .vsync_out(vsync), .bit_clk_out(bclk));

   initial begin
      forever #20 clk = ~clk;
   end

   // ----------------------------------------
   // compare and report
   // ----------------------------------------
   task automatic check(input string what, input logic [12:0] exp, input logic [12:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic end_sim;
      $display("mismatches %0d, comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   function automatic logic [11:0] code_word(input int idx, input bit v, input bit h,
      input bit ten);
      logic [3:0] prot;
      logic [11:0] w;
      prot = v ? (h ? 4'h6 : 4'hB) : (h ? 4'hD : 4'h0);
      case (idx)
         0: w = 12'hFFF;
         3: w = {2'b10, v, h, prot, 4'h0};
         default: w = 12'h000;
      endcase
      return ten ? (w >> 2) : w;
   endfunction

   // ----------------------------------------
   // drivers and output watcher
   // ----------------------------------------
   // pixel source holds each word until the buffer takes it
   always @(posedge clk) begin
      if (pix_valid === 1'b1 && pix_ready === 1'b1) void'(pix_q.pop_front());
      if (pix_q.size() > 0) begin
         pix <= pix_q[0];
         pix_valid <= 1'b1;
      end else begin
         pix_valid <= 1'b0;
      end
   end

   // receiver side: every word, blanking and sync codes included, is matched purely by order
   always @(posedge clk) begin
      if (!srst && word_valid === 1'b1) begin
         if (exp_q.size() == 0) check("extra word", 13'h1FFF, {sync_code, word});
         else check("word", exp_q.pop_front(), {sync_code, word});
      end
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         mismatches++;
         $display("unexpected run length: expected below 90000, seen %0d", cycles);
         end_sim();
      end
   end

   // one line: expectations first, then the controller paces it out
   task automatic do_line(input bit blank, input bit ten, input int npix, input bit frame,
      input int fb);
      pix_t p;
      logic [11:0] e;
      repeat (fb) exp_q.push_back(13'h0000);
      for (int i = 0; i < 4; i++) exp_q.push_back({1'b1, code_word(i, blank, 1'b0, ten)});
      for (int i = 0; i < npix; i++) begin
         p.last = (i == npix - 1);
         p.data = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : (i == 2) ? 12'h3FF : 12'($urandom);
         pix_q.push_back(p);
         e = ten ? {2'b00, p.data[9:0]} : p.data;
         if (e == 12'h000) e = 12'h001;
         if (e == (ten ? 12'h3FF : 12'hFFF)) e = ten ? 12'h3FE : 12'hFFE;
         exp_q.push_back({1'b0, e});
      end
      for (int i = 0; i < 4; i++) exp_q.push_back({1'b1, code_word(i, blank, 1'b1, ten)});
      repeat (3) exp_q.push_back(13'h0000);
      if (npix > 2) begin
         repeat (20) @(posedge clk);
         #1 check("ready while full", 13'h0, {12'h0, pix_ready});
      end
      i_src.run_line(fb + 11 + npix, frame);
      check("words left", 13'h0, 13'(exp_q.size()));
      check("blank line", {12'h0, blank}, {12'h0, blank_line});
      check("ready when drained", 13'h1, {12'h0, pix_ready});
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'hc5bf));
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      for (int m = 0; m < 9; m++) begin
         @(posedge clk);
         mode <= 4'(m);
         repeat (2) @(posedge clk);
         #1 check("lane mask", {3'b0, lanes[m]}, {3'b0, lane_en});
      end
      @(posedge clk);
      mode <= MODE_0;
      repeat (4) @(posedge clk);
      // 16 inverted-readout blanking lines, a 17th under normal readout, then active
      for (int l = 0; l < 16; l++) do_line(1'b1, 1'b0, 0, l == 0, 400);
      @(posedge clk);
      flip <= 1'b0;
      repeat (4) @(posedge clk);
      do_line(1'b1, 1'b0, 0, 1'b0, 400);
      @(posedge clk);
      flip <= 1'b1;
      repeat (4) @(posedge clk);
      do_line(1'b0, 1'b0, 6, 1'b0, 400);
      @(posedge clk);
      mode <= MODE_1;
      repeat (4) @(posedge clk);
      do_line(1'b0, 1'b1, 6, 1'b0, 400);
      // line 19 is still inside the longer dummy period of mode 3
      @(posedge clk);
      mode <= MODE_3;
      repeat (4) @(posedge clk);
      do_line(1'b1, 1'b0, 0, 1'b0, 406);
      @(posedge clk);
      mode <= MODE_4;
      repeat (4) @(posedge clk);
      do_line(1'b0, 1'b0, 3, 1'b0, 408);
      end_sim();
   end
endmodule
